/* File: hw/ovrs_pkg.sv */
// constants, types and register layout of the overvoltage retry sequencer
package ovrs_pkg;
  // ==========================================================
  // codes and settings
  localparam logic [7:0] OV_TRIP_CODE = 8'h07;
  localparam logic [7:0] OC_TRIP_CODE = 8'h01;
  localparam logic [2:0] LIMIT_MAX = 3'h5;
  localparam logic [2:0] LIMIT_DEF = 3'h0;
  localparam logic [2:0] MODE_ZERO_HZ = 3'h0;
  localparam logic [2:0] MODE_ENCODER = 3'h3;
  localparam logic [2:0] MODE_DECEL_TRIP = 3'h4;
  localparam logic [2:0] MODE_DEF = 3'h1;
  // wait settings count tenths of a second
  localparam logic [9:0] WAIT_MIN = 10'h003;
  localparam logic [9:0] WAIT_MAX = 10'h3e8;
  localparam logic [9:0] WAIT_DEF = 10'h003;
  localparam int WAIT_UNIT_MS = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAIT_UNIT_CYCLES = WAIT_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OV_WAIT = 8'h04;
  localparam logic [7:0] OFS_OC_WAIT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_FREQ = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01, ST_WAIT = 5'h02, ST_RESTART = 5'h04,
    ST_DECEL = 5'h08, ST_TRIP = 5'h10
  } ovrs_st_t;
  typedef struct packed {
    logic clear_trip; logic [18:0] rsv;
    logic [2:0] oc_mode; logic [2:0] oc_limit;
    logic [2:0] ov_mode; logic [2:0] ov_limit;
  } ovrs_ctrl_t;
  typedef struct packed {
    logic [10:0] rsv; logic alarm; logic [7:0] code;
    logic [2:0] oc_cnt; logic [2:0] ov_cnt; logic src_oc; logic [4:0] st;
  } ovrs_status_t;
  typedef struct packed {
    logic trip; logic restart; logic detect;
  } ovrs_irq_t;
  // ==========================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic awvalid; logic [ADDR_W-1:0] awaddr;
    logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [ADDR_W-1:0] araddr; logic rready;
  } ovrs_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } ovrs_axi_rsp_t;
endpackage : ovrs_pkg

/* File: hw/ovrs_sequencer.sv */
// overvoltage and overcurrent retry sequencer with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ovrs_sequencer #(
  parameter int unsigned UNIT_CYCLES = ovrs_pkg::WAIT_UNIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire ovrs_pkg::ovrs_axi_req_t axi_req,
  output ovrs_pkg::ovrs_axi_rsp_t axi_rsp,
  input wire logic ov_detect,
  input wire logic oc_detect,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] encoder_speed,
  input wire logic restart_done,
  input wire logic stop_done,
  output logic power_enable,
  output logic restart_start,
  output logic [2:0] restart_mode,
  output logic [15:0] restart_freq,
  output logic decel_stop_req,
  output logic fault_alarm_output,
  output logic [7:0] trip_code,
  output logic irq
);
  import ovrs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    ovrs_st_t st;
    logic src_oc;
    logic [2:0] ov_cnt;
    logic [2:0] oc_cnt;
    logic [7:0] code;
    logic [2:0] ov_limit;
    logic [2:0] ov_mode;
    logic [2:0] oc_limit;
    logic [2:0] oc_mode;
    logic [9:0] ov_wait;
    logic [9:0] oc_wait;
    logic [9:0] tenth;
    logic [31:0] tick;
    logic [15:0] freq;
    logic start;
    ovrs_irq_t irq_sts;
    ovrs_irq_t irq_mask;
    logic ov_s1;
    logic ov_s2;
    logic oc_s1;
    logic oc_s2;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ovrs_state_t;

  ovrs_state_t state_reg;
  ovrs_state_t state_next;

  function automatic logic [31:0] ovrs_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction : ovrs_merge

  function automatic logic [9:0] ovrs_clamp_wait(input logic [9:0] w);
    logic [9:0] c;
    c = w;
    if (w < WAIT_MIN) begin
      c = WAIT_MIN;
    end else if (w > WAIT_MAX) begin
      c = WAIT_MAX;
    end
    return c;
  endfunction : ovrs_clamp_wait

  // ==========================================================
  // register views
  ovrs_ctrl_t ctrl_rd;
  ovrs_status_t status_rd;
  logic [2:0] cur_mode;
  logic [9:0] cur_wait;

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd.ov_limit = state_reg.ov_limit;
    ctrl_rd.ov_mode = state_reg.ov_mode;
    ctrl_rd.oc_limit = state_reg.oc_limit;
    ctrl_rd.oc_mode = state_reg.oc_mode;
    status_rd = '0;
    status_rd.st = state_reg.st;
    status_rd.src_oc = state_reg.src_oc;
    status_rd.ov_cnt = state_reg.ov_cnt;
    status_rd.oc_cnt = state_reg.oc_cnt;
    status_rd.code = state_reg.code;
    status_rd.alarm = fault_alarm_output;
    cur_mode = state_reg.src_oc ? state_reg.oc_mode : state_reg.ov_mode;
    cur_wait = state_reg.src_oc ? state_reg.oc_wait : state_reg.ov_wait;
  end

  // ==========================================================
  // outputs
  logic fault_now;

  assign fault_now = state_reg.ov_s2 || state_reg.oc_s2;
  // gated straight from the synced pin so the cut does not wait a cycle
  assign power_enable = (state_reg.st == ST_RUN || state_reg.st == ST_RESTART ||
                         state_reg.st == ST_DECEL) && !fault_now;
  assign restart_start = state_reg.start;
  assign restart_mode = cur_mode;
  assign restart_freq = state_reg.freq;
  assign decel_stop_req = (state_reg.st == ST_DECEL);
  assign fault_alarm_output = (state_reg.st == ST_TRIP);
  assign trip_code = state_reg.code;
  assign irq = |(state_reg.irq_sts & state_reg.irq_mask);

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = !state_reg.aw_got && !state_reg.bvalid;
    axi_rsp.wready = !state_reg.w_got && !state_reg.bvalid;
    axi_rsp.bvalid = state_reg.bvalid;
    axi_rsp.bresp = state_reg.bresp;
    axi_rsp.arready = !state_reg.rvalid;
    axi_rsp.rvalid = state_reg.rvalid;
    axi_rsp.rdata = state_reg.rdata;
    axi_rsp.rresp = state_reg.rresp;
  end

  // ==========================================================
  // next state
  ovrs_ctrl_t cw;
  ovrs_irq_t ev;
  ovrs_irq_t clr;
  logic [31:0] m;
  logic clr_trip;
  logic f_oc;
  logic [2:0] f_cnt;
  logic [2:0] f_lim;
  logic f_trip;
  logic expire;

  always_comb begin
    state_next = state_reg;
    cw = '0;
    ev = '0;
    clr = '0;
    m = '0;
    clr_trip = 1'b0;
    state_next.start = 1'b0;
    state_next.ov_s1 = ov_detect;
    state_next.ov_s2 = state_reg.ov_s1;
    state_next.oc_s1 = oc_detect;
    state_next.oc_s2 = state_reg.oc_s1;

    // write channel: address and data taken in either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = axi_req.wdata;
      state_next.wstrb = axi_req.wstrb;
    end
    if (state_reg.aw_got && state_reg.w_got) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      case (state_reg.awaddr)
        OFS_CTRL: begin
          m = ovrs_merge(ctrl_rd, state_reg.wdata, state_reg.wstrb);
          cw = ovrs_ctrl_t'(m);
          state_next.ov_limit = (cw.ov_limit > LIMIT_MAX) ? LIMIT_MAX : cw.ov_limit;
          state_next.oc_limit = (cw.oc_limit > LIMIT_MAX) ? LIMIT_MAX : cw.oc_limit;
          // undefined modes are refused, old value kept
          if (cw.ov_mode <= MODE_DECEL_TRIP) begin
            state_next.ov_mode = cw.ov_mode;
          end
          if (cw.oc_mode <= MODE_DECEL_TRIP) begin
            state_next.oc_mode = cw.oc_mode;
          end
          clr_trip = cw.clear_trip && state_reg.wstrb[3];
        end
        OFS_OV_WAIT: begin
          m = ovrs_merge({22'h0, state_reg.ov_wait}, state_reg.wdata, state_reg.wstrb);
          state_next.ov_wait = ovrs_clamp_wait(m[9:0]);
        end
        OFS_OC_WAIT: begin
          m = ovrs_merge({22'h0, state_reg.oc_wait}, state_reg.wdata, state_reg.wstrb);
          state_next.oc_wait = ovrs_clamp_wait(m[9:0]);
        end
        OFS_IRQ_STS: begin
          if (state_reg.wstrb[0]) begin
            clr = ovrs_irq_t'(state_reg.wdata[2:0]);
          end
        end
        OFS_IRQ_MASK: begin
          if (state_reg.wstrb[0]) begin
            state_next.irq_mask = ovrs_irq_t'(state_reg.wdata[2:0]);
          end
        end
        OFS_STATUS, OFS_FREQ: begin
        end
        default: begin
          state_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && axi_req.bready) begin
      state_next.bvalid = 1'b0;
    end

    // read channel
    if (axi_req.arvalid && axi_rsp.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      case (axi_req.araddr)
        OFS_CTRL: state_next.rdata = ctrl_rd;
        OFS_OV_WAIT: state_next.rdata = {22'h0, state_reg.ov_wait};
        OFS_OC_WAIT: state_next.rdata = {22'h0, state_reg.oc_wait};
        OFS_STATUS: state_next.rdata = status_rd;
        OFS_IRQ_STS: state_next.rdata = {29'h0, state_reg.irq_sts};
        OFS_IRQ_MASK: state_next.rdata = {29'h0, state_reg.irq_mask};
        OFS_FREQ: state_next.rdata = {16'h0, state_reg.freq};
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && axi_req.rready) begin
      state_next.rvalid = 1'b0;
    end

    // sequencer: overvoltage takes priority when both faults show
    f_oc = !state_reg.ov_s2 && state_reg.oc_s2;
    f_cnt = f_oc ? state_reg.oc_cnt : state_reg.ov_cnt;
    f_lim = f_oc ? state_reg.oc_limit : state_reg.ov_limit;
    f_trip = ({1'b0, f_cnt} + 4'h1) > {1'b0, f_lim};
    expire = 1'b0;

    case (state_reg.st)
      ST_WAIT: begin
        if (state_reg.tick == 32'(UNIT_CYCLES - 1)) begin
          state_next.tick = 32'h0;
          state_next.tenth = state_reg.tenth + 10'h001;
          expire = (state_reg.tenth + 10'h001) >= cur_wait;
        end else begin
          state_next.tick = state_reg.tick + 32'h1;
        end
      end
      ST_TRIP: begin
        if (clr_trip) begin
          state_next.st = ST_RUN;
          state_next.ov_cnt = 3'h0;
          state_next.oc_cnt = 3'h0;
          state_next.code = 8'h0;
        end
      end
      default: begin
      end
    endcase

    // detection: in run, restart and decel at once, in wait only at expiry
    if ((fault_now && (state_reg.st == ST_RUN || state_reg.st == ST_RESTART ||
        state_reg.st == ST_DECEL)) || (fault_now && expire)) begin
      ev.detect = 1'b1;
      state_next.src_oc = f_oc;
      if (state_reg.st != ST_WAIT) begin
        state_next.freq = output_freq;
      end
      if (f_oc) begin
        state_next.oc_cnt = f_cnt + 3'h1;
      end else begin
        state_next.ov_cnt = f_cnt + 3'h1;
      end
      if (f_trip) begin
        state_next.st = ST_TRIP;
        state_next.code = f_oc ? OC_TRIP_CODE : OV_TRIP_CODE;
        ev.trip = 1'b1;
      end else begin
        state_next.st = ST_WAIT;
        state_next.tick = 32'h0;
        state_next.tenth = 10'h0;
      end
    end else if (expire) begin
      state_next.st = ST_RESTART;
      state_next.start = 1'b1;
      ev.restart = 1'b1;
      case (cur_mode)
        MODE_ZERO_HZ: state_next.freq = 16'h0;
        MODE_ENCODER: state_next.freq = encoder_speed;
        default: begin
          // retraction, matching and decel trip keep the captured frequency
          state_next.freq = state_reg.freq;
        end
      endcase
    end else if (state_reg.st == ST_RESTART && restart_done) begin
      state_next.st = (cur_mode == MODE_DECEL_TRIP) ? ST_DECEL : ST_RUN;
    end else if (state_reg.st == ST_DECEL && stop_done) begin
      state_next.st = ST_TRIP;
      state_next.code = state_reg.src_oc ? OC_TRIP_CODE : OV_TRIP_CODE;
      ev.trip = 1'b1;
    end

    // set wins over a write-one clear in the same cycle
    state_next.irq_sts = (state_reg.irq_sts & ~clr) | ev;
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.st <= ST_RUN;
      state_reg.ov_limit <= LIMIT_DEF;
      state_reg.oc_limit <= LIMIT_DEF;
      state_reg.ov_mode <= MODE_DEF;
      state_reg.oc_mode <= MODE_DEF;
      state_reg.ov_wait <= WAIT_DEF;
      state_reg.oc_wait <= WAIT_DEF;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  trip_at_zero_a: assert property (ce && state_reg.st == ST_RUN && state_reg.ov_s2 &&
      state_reg.ov_limit == 3'h0 |=> state_reg.st == ST_TRIP && trip_code == OV_TRIP_CODE)
    else $error("zero limit did not trip");
  retry_wait_a: assert property (ce && state_reg.st == ST_RUN && state_reg.ov_s2 &&
      state_reg.ov_cnt < state_reg.ov_limit |=> state_reg.st == ST_WAIT && !fault_alarm_output)
    else $error("retry did not enter wait");
  limit_exceed_a: assert property (ce && state_reg.ov_s2 &&
      (state_reg.st == ST_RUN || state_reg.st == ST_RESTART) &&
      state_reg.ov_cnt >= state_reg.ov_limit |=> state_reg.st == ST_TRIP)
    else $error("exceeded limit without trip");
  limit_range_a: assert property (state_reg.ov_limit <= LIMIT_MAX && state_reg.oc_limit <= LIMIT_MAX)
    else $error("retry limit out of range");
  wait_range_a: assert property (state_reg.ov_wait >= WAIT_MIN && state_reg.ov_wait <= WAIT_MAX)
    else $error("wait setting out of range");
  power_cut_a: assert property (fault_now |-> !power_enable)
    else $error("power on during fault");
  alarm_trip_a: assert property (fault_alarm_output |-> trip_code != 8'h0)
    else $error("alarm without error code");
  zero_hz_a: assert property (restart_start && restart_mode == MODE_ZERO_HZ |->
      restart_freq == 16'h0 && !fault_alarm_output)
    else $error("zero hertz restart wrong");
  restart_start_a: assert property (restart_start && $past(ce) &&
      $past(restart_mode) != MODE_ZERO_HZ && $past(restart_mode) != MODE_ENCODER |->
      $past(state_reg.st == ST_WAIT) && restart_freq == $past(state_reg.freq))
    else $error("restart not from captured frequency");
  decel_trip_a: assert property (ce && state_reg.st == ST_DECEL && stop_done && !fault_now |=>
      fault_alarm_output && !power_enable)
    else $error("decel stop did not trip");
endmodule : ovrs_sequencer
`default_nettype wire

/* File: tb/ovrs_drive_model.sv */
// behavioural power stage and fault pins facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module ovrs_drive_model #(
  parameter logic [15:0] RUN_FREQ = 16'h1234,
  parameter logic [15:0] ENC_SPEED = 16'h0abc
) (
  input wire logic aclk,
  input wire logic ov_cmd,
  input wire logic oc_cmd,
  input wire logic slow,
  input wire logic restart_start,
  input wire logic decel_stop_req,
  output logic ov_detect,
  output logic oc_detect,
  output logic [15:0] output_freq,
  output logic [15:0] encoder_speed,
  output logic restart_done,
  output logic stop_done
);
  // ==========================================================
  // fault pins and motor feedback
  int rcnt = 0;
  int dcnt = 0;
  int lim;
  assign lim = slow ? 6 : 1;
  assign ov_detect = ov_cmd;
  assign oc_detect = oc_cmd;
  // held through the coast so the captured value is known
  assign output_freq = RUN_FREQ;
  assign encoder_speed = ENC_SPEED;
  // ==========================================================
  // restart engine and decelerating stop, prompt or slow
  always @(posedge aclk) begin
    restart_done <= 1'b0;
    stop_done <= 1'b0;
    if (restart_start) rcnt <= lim;
    else if (rcnt > 0) begin
      rcnt <= rcnt - 1;
      restart_done <= (rcnt == 1);
    end
    // one pulse only, the request may linger an edge after it
    if (!decel_stop_req) dcnt <= 0;
    else if (dcnt <= lim) begin
      dcnt <= dcnt + 1;
      stop_done <= (dcnt == lim);
    end
  end
endmodule : ovrs_drive_model
`default_nettype wire

/* File: tb/ovrs_sequencer_test.sv */
// self-checking bench for the overvoltage retry sequencer
`timescale 1ns/1ps
`default_nettype none
module ovrs_sequencer_test;
  import ovrs_pkg::*;
  // ==========================================================
  // signals and instances
  localparam logic [15:0] RUN_FREQ = 16'h1234;
  localparam logic [15:0] ENC_SPEED = 16'h0abc;
  logic aclk, aresetn, ov_cmd, oc_cmd, slow, ov_detect, oc_detect, restart_done, stop_done, ce;
  logic power_enable, restart_start, decel_stop_req, fault_alarm_output, irq;
  logic [2:0] restart_mode;
  logic [7:0] trip_code;
  logic [15:0] restart_freq, output_freq, encoder_speed;
  logic [15:0] exp_f [5];
  ovrs_axi_req_t req;
  ovrs_axi_rsp_t rsp;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int starts = 0;
  int n, s0;
  ovrs_sequencer #(.UNIT_CYCLES(4)) i_ovrs_sequencer (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req), .axi_rsp(rsp),
    .ov_detect(ov_detect), .oc_detect(oc_detect), .output_freq(output_freq),
    .encoder_speed(encoder_speed), .restart_done(restart_done), .stop_done(stop_done),
    .power_enable(power_enable), .restart_start(restart_start), .restart_mode(restart_mode),
    .restart_freq(restart_freq), .decel_stop_req(decel_stop_req),
    .fault_alarm_output(fault_alarm_output), .trip_code(trip_code), .irq(irq));
  ovrs_drive_model #(.RUN_FREQ(RUN_FREQ), .ENC_SPEED(ENC_SPEED)) i_ovrs_drive_model (
    .aclk(aclk), .ov_cmd(ov_cmd), .oc_cmd(oc_cmd), .slow(slow),
    .restart_start(restart_start), .decel_stop_req(decel_stop_req),
    .ov_detect(ov_detect), .oc_detect(oc_detect), .output_freq(output_freq),
    .encoder_speed(encoder_speed), .restart_done(restart_done), .stop_done(stop_done));
  // ==========================================================
  // helpers
  task automatic final_report;
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic sig(input int w);
    case (w)
      0: return restart_start;
      1: return restart_done;
      2: return decel_stop_req;
      3: return fault_alarm_output;
      default: return !power_enable;
    endcase
  endfunction : sig
  task automatic wait_sig(input int w);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sig(w) !== 1'b1 && n < 300);
    if (n >= 300) chk("wait event", 32'(w), 32'hffff_ffff);
  endtask : wait_sig
  // bready and rready stay high, so no release is needed between transfers
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    int k;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    k = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    do begin
      @(posedge aclk);
      k++;
      if (!aw_ok && rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok) && k < 100);
    do begin
      @(posedge aclk);
      k++;
    end while (rsp.bvalid !== 1'b1 && k < 200);
    chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge aclk);
      k++;
    end while (rsp.arready !== 1'b1 && k < 100);
    req.arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
    end while (rsp.rvalid !== 1'b1 && k < 200);
    chk("rdata", rsp.rdata, ed);
    chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
  endtask : rd
  // pin up, cut seen, state settled, pin released unless held
  task automatic raise(input logic oc, input logic hold);
    if (oc) oc_cmd <= 1'b1;
    else ov_cmd <= 1'b1;
    wait_sig(4);
    chk("cut delay", {31'h0, n <= 3}, 32'h1);
    repeat (2) @(posedge aclk);
    if (!hold) ov_cmd <= 1'b0;
    if (!hold) oc_cmd <= 1'b0;
  endtask : raise
  // ==========================================================
  // clock, timeout, restart pulse count
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (restart_start === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      errors++;
      final_report;
    end
  end
  // ==========================================================
  // test sequence
  initial begin
    exp_f = '{16'h0000, RUN_FREQ, 16'h0000, ENC_SPEED, RUN_FREQ};
    aresetn = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hf;
    ov_cmd = 1'b0;
    oc_cmd = 1'b0;
    slow = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL, 32'h0000_0208, RESP_OKAY);
    rd(OFS_OV_WAIT, 32'h0000_0003, RESP_OKAY);
    wr(OFS_OV_WAIT, 32'h0000_0001, RESP_OKAY);
    rd(OFS_OV_WAIT, 32'h0000_0003, RESP_OKAY);
    wr(OFS_OV_WAIT, 32'h0000_07ff, RESP_OKAY);
    rd(OFS_OV_WAIT, 32'h0000_03e8, RESP_OKAY);
    wr(OFS_OV_WAIT, 32'h0000_0003, RESP_OKAY);
    // limit clamps, undefined modes keep the old value
    wr(OFS_CTRL, 32'h0000_0e3f, RESP_OKAY);
    rd(OFS_CTRL, 32'h0000_020d, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0208, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
    // zero limit trips at once
    raise(1'b0, 1'b0);
    chk("trip_code", {24'h0, trip_code}, {24'h0, OV_TRIP_CODE});
    chk("alarm", {31'h0, fault_alarm_output}, 32'h1);
    chk("starts", starts, 0);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STS, 32'h7, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(OFS_CTRL, 32'h8000_0208, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    // limit five, one detection per mode, events masked
    wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
    for (int m = 0; m < 5; m++) begin
      slow <= m[0];
      wr(OFS_CTRL, 32'h0000_0205 | (32'(m) << 3), RESP_OKAY);
      raise(1'b0, 1'b0);
      wait_sig(0);
      chk("wait", {31'h0, n >= 8}, 32'h1);
      if (m != 2) chk("freq", {16'h0, restart_freq}, {16'h0, exp_f[m]});
      chk("restart_mode", {29'h0, restart_mode}, 32'(m));
      chk("alarm", {31'h0, fault_alarm_output}, 32'h0);
      if (m < 4) begin
        wait_sig(1);
        rd(OFS_STATUS, 32'h1 | (32'(m + 1) << 6), RESP_OKAY);
        if (m != 2) rd(OFS_FREQ, {16'h0, exp_f[m]}, RESP_OKAY);
      end else begin
        wait_sig(2);
        chk("alarm", {31'h0, fault_alarm_output}, 32'h0);
        wait_sig(3);
        chk("trip_code", {24'h0, trip_code}, {24'h0, OV_TRIP_CODE});
      end
    end
    rd(OFS_IRQ_STS, 32'h0000_0007, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_STS, 32'h7, RESP_OKAY);
    wr(OFS_CTRL, 32'h8000_0201, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    // fault still present at expiry counts again and trips
    s0 = starts;
    raise(1'b0, 1'b1);
    wait_sig(3);
    chk("starts", starts, s0);
    chk("trip_code", {24'h0, trip_code}, {24'h0, OV_TRIP_CODE});
    ov_cmd <= 1'b0;
    repeat (3) @(posedge aclk);
    wr(OFS_CTRL, 32'h8000_0208, RESP_OKAY);
    // pins frozen while the enable is low, seen once it returns
    ce <= 1'b0;
    ov_cmd <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("frozen", {31'h0, power_enable}, 32'h1);
    ce <= 1'b1;
    wait_sig(3);
    chk("trip_code", {24'h0, trip_code}, {24'h0, OV_TRIP_CODE});
    ov_cmd <= 1'b0;
    repeat (3) @(posedge aclk);
    wr(OFS_CTRL, 32'h8000_0208, RESP_OKAY);
    wr(OFS_OC_WAIT, 32'h0000_0004, RESP_OKAY);
    // overcurrent encoder and matching restarts
    for (int m = 3; m >= 2; m--) begin
      wr(OFS_CTRL, 32'h0000_0088 | (32'(m) << 9), RESP_OKAY);
      raise(1'b1, 1'b0);
      wait_sig(0);
      chk("wait", {31'h0, n >= 12}, 32'h1);
      chk("restart_mode", {29'h0, restart_mode}, 32'(m));
      chk("alarm", {31'h0, fault_alarm_output}, 32'h0);
      if (m == 3) chk("freq", {16'h0, restart_freq}, {16'h0, ENC_SPEED});
      wait_sig(1);
    end
    // third overcurrent beyond a limit of two trips with its own code
    raise(1'b1, 1'b0);
    chk("trip_code", {24'h0, trip_code}, {24'h0, OC_TRIP_CODE});
    chk("alarm", {31'h0, fault_alarm_output}, 32'h1);
    // drive reset after a trip clears the counts and returns to run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    final_report;
  end
endmodule : ovrs_sequencer_test
`default_nettype wire
